// ===== rtl/switch_pkg.sv
package switch_pkg;

    // port counts and path widths
    localparam int MASTER_COUNT = 3;
    localparam int SLAVE_COUNT  = 4;
    localparam int ADDR_WIDTH   = 32;
    localparam int DATA_WIDTH   = 64;
    localparam int MID_WIDTH    = 2;

    // master identifiers, lowest number wins a round-robin tie after reset
    localparam logic [MID_WIDTH-1:0] MASTER_FETCH = 2'h0;
    localparam logic [MID_WIDTH-1:0] MASTER_DATA  = 2'h1;
    localparam logic [MID_WIDTH-1:0] MASTER_DMA   = 2'h2;

    // slave port index, taken from the top two address bits
    localparam int SLAVE_SEL_MSB = 31;
    localparam int SLAVE_SEL_LSB = 30;
    localparam logic [1:0] SLAVE_FLASH  = 2'h0;
    localparam logic [1:0] SLAVE_CALIB  = 2'h1;
    localparam logic [1:0] SLAVE_SRAM   = 2'h2;
    localparam logic [1:0] SLAVE_BRIDGE = 2'h3;

    // reset values
    localparam logic [MID_WIDTH-1:0] LAST_GRANT_RESET = MASTER_DMA;
    localparam logic [1:0]           PRIORITY_RESET   = 2'h0;

    // request from a master toward the switch
    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic                  last;   // final beat of the master's transactions
        logic [1:0]            prio;
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
    } master_req_s;

    // answer returned to a master
    typedef struct packed {
        logic                  ready;
        logic [DATA_WIDTH-1:0] rdata;
    } master_rsp_s;

    // request presented on a slave port
    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic [MID_WIDTH-1:0]  master;
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
    } slave_req_s;

    // answer from a slave port
    typedef struct packed {
        logic                  ready;
        logic [DATA_WIDTH-1:0] rdata;
    } slave_rsp_s;

endpackage : switch_pkg

// ===== rtl/multi_port_switch.sv
module multi_port_switch
    import switch_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire master_req_s fetch_req,
    input  wire master_req_s data_req,
    input  wire master_req_s dma_master_req,
    output master_rsp_s      fetch_rsp,
    output master_rsp_s      data_rsp,
    output master_rsp_s      dma_master_rsp,
    output slave_req_s       flash_req,
    output slave_req_s       calib_req,
    output slave_req_s       sram_req,
    output slave_req_s       bridge_req,
    input  wire slave_rsp_s  flash_rsp,
    input  wire slave_rsp_s  calib_rsp,
    input  wire slave_rsp_s  sram_rsp,
    input  wire slave_rsp_s  bridge_rsp
);

    master_req_s mreq [MASTER_COUNT];
    master_rsp_s mrsp [MASTER_COUNT];
    master_rsp_s next_mrsp [MASTER_COUNT];
    slave_req_s  sreq [SLAVE_COUNT];
    slave_req_s  next_sreq [SLAVE_COUNT];
    slave_rsp_s  srsp [SLAVE_COUNT];

    // owner state per slave port
    logic [SLAVE_COUNT-1:0] owned;
    logic [SLAVE_COUNT-1:0] next_owned;
    logic [MID_WIDTH-1:0]   owner      [SLAVE_COUNT];
    logic [MID_WIDTH-1:0]   next_owner [SLAVE_COUNT];
    logic [MID_WIDTH-1:0]   last_grant      [SLAVE_COUNT];
    logic [MID_WIDTH-1:0]   next_last_grant [SLAVE_COUNT];
    logic [MASTER_COUNT-1:0] busy;      // request issued, waiting for slave ready
    logic [MASTER_COUNT-1:0] next_busy;

    // fixed role of each master and slave port
    assign mreq[MASTER_FETCH] = fetch_req;
    assign mreq[MASTER_DATA]  = data_req;
    assign mreq[MASTER_DMA]   = dma_master_req;
    assign fetch_rsp          = mrsp[MASTER_FETCH];
    assign data_rsp           = mrsp[MASTER_DATA];
    assign dma_master_rsp     = mrsp[MASTER_DMA];
    assign flash_req          = sreq[SLAVE_FLASH];
    assign calib_req          = sreq[SLAVE_CALIB];
    assign sram_req           = sreq[SLAVE_SRAM];
    assign bridge_req         = sreq[SLAVE_BRIDGE];
    assign srsp[SLAVE_FLASH]  = flash_rsp;
    assign srsp[SLAVE_CALIB]  = calib_rsp;
    assign srsp[SLAVE_SRAM]   = sram_rsp;
    assign srsp[SLAVE_BRIDGE] = bridge_rsp;

    // arbitration, one independent arbiter per slave port
    always_comb begin
        logic [MASTER_COUNT-1:0] want;
        logic [1:0]              best_prio;
        logic                    found;
        logic [MID_WIDTH-1:0]    pick;
        logic [MID_WIDTH-1:0]    cand;
        logic [MID_WIDTH-1:0]    cur;
        logic                    done;
        want      = '0;
        best_prio = PRIORITY_RESET;
        found     = 1'b0;
        pick      = '0;
        cand      = '0;
        cur       = '0;
        done      = 1'b0;
        next_owned = owned;
        next_busy  = busy;
        for (int m = 0; m < MASTER_COUNT; m++) begin
            next_mrsp[m] = '{ready: 1'b0, rdata: mrsp[m].rdata};
        end
        for (int s = 0; s < SLAVE_COUNT; s++) begin
            next_owner[s]      = owner[s];
            next_last_grant[s] = last_grant[s];
            next_sreq[s]       = sreq[s];
            next_sreq[s].valid = 1'b0;
        end
        for (int s = 0; s < SLAVE_COUNT; s++) begin
            // a finished beat frees the owner; last beat releases the port
            if (sreq[s].valid && srsp[s].ready) begin
                cur                 = sreq[s].master;
                next_busy[cur]      = 1'b0;
                next_mrsp[cur].ready = 1'b1;
                next_mrsp[cur].rdata = srsp[s].rdata;
                if (mreq[cur].last) begin
                    next_owned[s] = 1'b0;
                end
            end
            // masters idle enough to issue a new beat toward this slave
            for (int m = 0; m < MASTER_COUNT; m++) begin
                want[m] = mreq[m].valid && !busy[m] && !mrsp[m].ready
                    && (mreq[m].addr[SLAVE_SEL_MSB:SLAVE_SEL_LSB] == 2'(s));
            end
            if (!owned[s]) begin
                // highest priority among requesters
                found     = 1'b0;
                best_prio = PRIORITY_RESET;
                for (int m = 0; m < MASTER_COUNT; m++) begin
                    if (want[m] && (!found || mreq[m].prio > best_prio)) begin
                        best_prio = mreq[m].prio;
                        found     = 1'b1;
                    end
                end
                // round-robin among equals, starting after the last grant
                done = 1'b0;
                pick = '0;
                for (int k = 1; k <= MASTER_COUNT; k++) begin
                    cand = MID_WIDTH'((int'(last_grant[s]) + k) % MASTER_COUNT);
                    if (!done && want[cand] && mreq[cand].prio == best_prio) begin
                        pick = cand;
                        done = 1'b1;
                    end
                end
                if (found) begin
                    next_owned[s]      = 1'b1;
                    next_owner[s]      = pick;
                    next_last_grant[s] = pick;
                end
            end else if (!sreq[s].valid && want[owner[s]]) begin
                pick = owner[s];
                done = 1'b1;
                found = 1'b1;
            end else begin
                found = 1'b0;
            end
            // launch the owner's beat; losers see no ready and stay pending
            if (found && (!owned[s] || !sreq[s].valid)) begin
                next_busy[pick]     = 1'b1;
                next_sreq[s].valid  = 1'b1;
                next_sreq[s].write  = mreq[pick].write;
                next_sreq[s].master = pick;
                next_sreq[s].addr   = mreq[pick].addr;
                next_sreq[s].wdata  = mreq[pick].wdata;
            end else if (sreq[s].valid && !srsp[s].ready) begin
                next_sreq[s].valid = 1'b1;  // hold until the slave accepts
            end
        end
    end

    // all ports registered; distinct slaves advance in parallel
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            owned <= '0;
            busy  <= '0;
            for (int s = 0; s < SLAVE_COUNT; s++) begin
                owner[s]      <= '0;
                last_grant[s] <= LAST_GRANT_RESET;
                sreq[s]       <= '0;
            end
            for (int m = 0; m < MASTER_COUNT; m++) begin
                mrsp[m] <= '0;
            end
        end else begin
            owned <= next_owned;
            busy  <= next_busy;
            for (int s = 0; s < SLAVE_COUNT; s++) begin
                owner[s]      <= next_owner[s];
                last_grant[s] <= next_last_grant[s];
                sreq[s]       <= next_sreq[s];
            end
            for (int m = 0; m < MASTER_COUNT; m++) begin
                mrsp[m] <= next_mrsp[m];
            end
        end
    end

endmodule : multi_port_switch

// ===== bench/switch_asserts.sv
module switch_asserts
    import switch_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire master_req_s dma_master_req,
    input wire master_rsp_s fetch_rsp,
    input wire slave_req_s  flash_req,
    input wire slave_req_s  sram_req,
    input wire slave_req_s  bridge_req,
    input wire slave_rsp_s  flash_rsp,
    input wire slave_rsp_s  sram_rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // slave side must carry the granted master's beat; master answers and quiet after reset are checked too
    a_sram_holds: assert property (sram_req.valid && !sram_rsp.ready |=> sram_req.valid && $stable(sram_req.addr)) else $error("sram request dropped early");
    a_dma_addr: assert property (sram_req.valid && sram_req.master == MASTER_DMA |-> sram_req.addr == dma_master_req.addr) else $error("dma address not carried");
    a_sram_decode: assert property (sram_req.valid |-> sram_req.addr[31:30] == SLAVE_SRAM) else $error("wrong slave for sram");
    a_bridge_decode: assert property (bridge_req.valid |-> bridge_req.addr[31:30] == SLAVE_BRIDGE) else $error("wrong slave for bridge");
    a_master_id: assert property (bridge_req.valid |-> bridge_req.master < 2'h3) else $error("no such master");
    a_flash_answer: assert property (flash_req.valid && flash_rsp.ready && flash_req.master == MASTER_FETCH |=> fetch_rsp.ready ##1 !fetch_rsp.ready) else $error("fetch answer missing");
    a_flash_drops: assert property (flash_req.valid && flash_rsp.ready |=> !flash_req.valid) else $error("flash beat repeated");
    a_dma_grant: assert property ($rose(sram_req.valid) && sram_req.master == MASTER_DMA |-> $past(dma_master_req.valid)) else $error("grant without request");
    a_quiet_start: assert property (!$past(reset_n) |-> !sram_req.valid && !fetch_rsp.ready) else $error("output busy after reset");
endmodule : switch_asserts

bind multi_port_switch switch_asserts checker_inst (.sys_clk, .reset_n, .dma_master_req, .fetch_rsp,
    .flash_req, .sram_req, .bridge_req, .flash_rsp, .sram_rsp);

// ===== bench/slave_port_model.sv
module slave_port_model
    import switch_pkg::*;
#(
    parameter int DELAY = 0
)
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire slave_req_s req,
    output slave_rsp_s      rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    int          wait_cnt;
    logic [63:0] word;
    // data off the ready cycle is inverted so a stale capture is caught
    assign word = {~req.addr, req.addr};
    assign rsp.ready = req.valid && wait_cnt == DELAY;
    assign rsp.rdata = rsp.ready ? word : ~word;
    // wait states before each answer
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_cnt <= 0;
        end else begin
            wait_cnt <= (req.valid && !rsp.ready) ? wait_cnt + 1 : 0;
        end
    end
endmodule : slave_port_model

// ===== bench/multi_port_switch_tb.sv
module multi_port_switch_tb;
    import switch_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    master_req_s mreq [3];
    master_rsp_s mrsp [3];
    slave_req_s  sreq [4];
    slave_rsp_s  srsp [4];
    int          mismatches = 0;
    int          comparisons = 0;
    always #50 sys_clk = ~sys_clk;
    multi_port_switch dut (.sys_clk, .reset_n, .fetch_req(mreq[0]), .data_req(mreq[1]),
        .dma_master_req(mreq[2]), .fetch_rsp(mrsp[0]), .data_rsp(mrsp[1]),
        .dma_master_rsp(mrsp[2]), .flash_req(sreq[0]), .calib_req(sreq[1]),
        .sram_req(sreq[2]), .bridge_req(sreq[3]), .flash_rsp(srsp[0]),
        .calib_rsp(srsp[1]), .sram_rsp(srsp[2]), .bridge_rsp(srsp[3]));
    // slave n answers after n wait states
    for (genvar s = 0; s < 4; s++) begin : g_slave
        slave_port_model #(.DELAY(s)) model (.sys_clk, .reset_n, .req(sreq[s]), .rsp(srsp[s]));
    end
    task automatic complete_run();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask : check
    // one beat; n counts edges until ready, a stuck grant ends the run
    task automatic beat(input int m, input logic [31:0] a, input logic [1:0] p, output int n);
        @(posedge sys_clk);
        #1;
        mreq[m] = '{valid: 1'b1, write: 1'b0, last: 1'b1, prio: p, addr: a, wdata: 64'h0};
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (mrsp[m].ready !== 1'b1 && n < 40);
        mreq[m].valid = 1'b0;
        check(n < 40 && mrsp[m].rdata === {~a, a}, "beat data or timeout");
        if (n >= 40) complete_run();
    endtask : beat
    task automatic t_round_robin();
        int n0;
        int n2;
        fork
            beat(0, 32'hC000_0008, 2'h1, n0);
            beat(2, 32'hC000_0010, 2'h1, n2);
        join
        check(n0 == 5 && n2 > 5, "first grant not lowest");
        // fetch alone moves the last grant to 0, so dma is next in turn
        beat(0, 32'hC000_0028, 2'h1, n0);
        check(n0 == 5, "lone fetch latency");
        fork
            beat(0, 32'hC000_0018, 2'h1, n0);
            beat(2, 32'hC000_0020, 2'h1, n2);
        join
        check(n2 == 5 && n0 > 5, "round robin order");
        $display("test round robin done");
    endtask : t_round_robin
    task automatic t_parallel();
        int n0;
        int n1;
        int n2;
        fork
            beat(0, 32'h0000_0010, 2'h0, n0);
            beat(1, 32'h4000_0020, 2'h0, n1);
            beat(2, 32'h8000_0030, 2'h0, n2);
        join
        check(n0 == 2 && n1 == 3 && n2 == 4, "parallel latency");
        $display("test parallel done");
    endtask : t_parallel
    task automatic t_priority();
        int n1;
        int n2;
        fork
            beat(1, 32'h8000_0040, 2'h2, n1);
            beat(2, 32'h8000_0048, 2'h1, n2);
        join
        check(n1 == 4 && n2 > 4, "priority winner");
        $display("test priority done");
    endtask : t_priority
    initial begin
        for (int i = 0; i < 3; i++) begin
            mreq[i] = '0;
        end
        repeat (3) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        t_round_robin();
        t_parallel();
        t_priority();
        complete_run();
    end
endmodule : multi_port_switch_tb
